// ### wdt_cfg.svh
// watchdog constants: offsets, field positions, reset values, timing counts
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_CLEAR_OFF 16'hffff
`define WDT_CONFIG_OFF 16'h0000
`define WDT_STATUS_OFF 16'h0004
`define WDT_VECTOR_OFF 16'h0008
`define WDT_CLEAR_ADDR 32'h0003fffc
`define WDT_CONFIG_ADDR 32'h00000000
`define WDT_STATUS_ADDR 32'h00000004
`define WDT_VECTOR_ADDR 32'h00000008
`define WDT_CFG_RATE_BIT 0
`define WDT_CFG_DIS_BIT 1
`define WDT_CFG_STOPDIS_BIT 2
`define WDT_CFG_RESET 8'h00
`define WDT_VECTOR_RESET 8'h00
`define WDT_PRE_BITS 12
`define WDT_CNT_BITS 6
`define WDT_PRE_KEEP 4
`define WDT_RST_PULSE 32
`define WDT_POR_DELAY 4096
`endif

// ### wdt_pkg.sv
// watchdog types
package wdt_pkg;
  typedef struct packed {
    logic stop_disable;
    logic watchdog_disable;
    logic timeout_rate_select;
  } wdt_cfg_t;
  typedef struct packed {
    logic illegal_stop;
    logic watchdog_reset;
  } wdt_src_t;
  typedef struct packed {
    logic stop_exec;
    logic stop_mode;
    logic vector_fetch;
    logic internal_reset;
    logic monitor_mode;
    logic monitor_blank;
    logic break_state;
    logic tst_on_rst;
    logic tst_on_irq;
  } wdt_sys_t;
  typedef enum logic [1:0] {
    WDT_IDLE,
    WDT_PULSE
  } wdt_state_t;
endpackage

// ### wdt_prescaler.sv
// 12-bit prescaler with stage-selective clear
`timescale 1ns/1ns
`default_nettype none
`include "wdt_cfg.svh"
module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int PRE_BITS = `WDT_PRE_BITS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic clr_all,
  input wire logic clr_upper,
  output logic [PRE_BITS-1:0] count,
  output logic wrap
);
  logic [PRE_BITS-1:0] count_r;
  assign count = count_r;
  assign wrap = run && (&count_r) && !clr_all && !clr_upper;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= '0;
    else if (clr_all)
      count_r <= '0;
    else if (clr_upper)
      // stages 12..5 cleared, low four bits kept
      count_r <= {{(PRE_BITS-`WDT_PRE_KEEP){1'b0}},
                  count_r[`WDT_PRE_KEEP-1:0]};
    else if (run)
      count_r <= count_r + 1'b1;
  end
endmodule
`default_nettype wire

// ### wdt_counter.sv
// 6-bit watchdog counter advanced by prescaler taps
`timescale 1ns/1ns
`default_nettype none
`include "wdt_cfg.svh"
module wdt_counter
  import wdt_pkg::*;
#(
  parameter int CNT_BITS = `WDT_CNT_BITS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic clr,
  output logic overflow
);
  logic [CNT_BITS-1:0] cnt_r;
  assign overflow = tick && (&cnt_r) && !clr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else if (clr)
      cnt_r <= '0;
    else if (tick)
      cnt_r <= cnt_r + 1'b1;
  end
endmodule
`default_nettype wire

// ### wdt_top.sv
// watchdog top: apb registers, timeout, reset pulse, disable logic
//
// Summary of operation
// - 6-bit counter fed by 12-bit prescaler overflow, or by its low 7-bit tap with rate select set
// - timeout set by rate select; reset clears it
// - uncleared overflow raises system reset
// - clear write zeroes counter, prescaler stages 12..5
// - clear location reads reset vector low byte
// - reset pin low 32 cycles, source flag set
// - watchdog runs on undivided crystal clock
// - stop clears prescaler, clock gated in stop
// - prescaler cleared 4096 cycles after power-up
// - internal reset clears prescaler and counter
// - reset vector fetch clears prescaler
// - disable bit set means never a watchdog reset; illegal stop reset still works
// - monitor mode test voltage holds watchdog off
// - blank-vector monitor entry disables until power-on
// - break with test voltage on reset disables
// - watchdog keeps counting during wait mode
// - stop disabled makes stop an illegal-opcode reset
// - no cpu interrupt, only system reset
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_cfg.svh"
module wdt_top
  import wdt_pkg::*;
#(
  parameter int PRE_BITS = `WDT_PRE_BITS,
  parameter int CNT_BITS = `WDT_CNT_BITS,
  parameter int POR_DELAY = `WDT_POR_DELAY
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire wdt_sys_t sys_in,
  output logic sys_reset_n,
  output logic illegal_stop_reset
);
  localparam int PULSE_W = $clog2(`WDT_RST_PULSE + 1);
  localparam int POR_W = $clog2(POR_DELAY + 1);
  localparam int CFG_W = $bits(wdt_cfg_t);

  wdt_cfg_t cfg_r;
  wdt_src_t src_r;
  logic [7:0] vector_lo_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic sys_reset_n_r;
  logic illegal_r;
  logic blank_lock_r;
  logic [POR_W-1:0] por_cnt_r;
  logic por_done_r;
  logic por_clr;
  wdt_state_t state_r;
  logic [PULSE_W-1:0] pulse_r;
  logic [PRE_BITS-1:0] pre_count;
  logic pre_wrap;
  logic cnt_tick;
  logic overflow;
  logic disabled;
  logic run;
  logic clr_write;
  logic pre_clr_all;
  logic cnt_clr;
  logic setup;
  logic access;
  logic wr;
  logic rd;

  assign setup = psel && !penable;
  assign access = psel && penable && pready_r;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign clr_write = wr && (paddr == `WDT_CLEAR_ADDR);

  // test voltage dominates while present; blank entry sticks to power-on
  assign disabled = cfg_r.watchdog_disable
    || (sys_in.monitor_mode
      && (sys_in.tst_on_rst || sys_in.tst_on_irq))
    || blank_lock_r
    || (sys_in.break_state && sys_in.tst_on_rst);
  // wait mode is not an input: counting goes on through it
  assign run = !disabled && !sys_in.stop_mode;
  assign pre_clr_all = sys_in.stop_exec || sys_in.stop_mode
    || sys_in.internal_reset
    || sys_in.vector_fetch
    || por_clr
    || disabled;
  assign cnt_clr = clr_write || sys_in.internal_reset || disabled;

  // rate select picks the tap: 2^18-2^4 or 2^13-2^4 crystal cycles
  assign cnt_tick = cfg_r.timeout_rate_select ?
    (run && (&pre_count[6:0]) && !pre_clr_all && !clr_write) :
    (pre_wrap && !pre_clr_all);

  wdt_prescaler #(.PRE_BITS(PRE_BITS)) u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .clr_all(pre_clr_all),
    .clr_upper(clr_write),
    .count(pre_count),
    .wrap(pre_wrap)
  );

  wdt_counter #(.CNT_BITS(CNT_BITS)) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .tick(cnt_tick),
    .clr(cnt_clr),
    .overflow(overflow)
  );

  // power-on delay before the one-time prescaler clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_cnt_r <= '0;
      por_done_r <= 1'b0;
    end
    else if (!por_done_r)
    begin
      por_cnt_r <= por_cnt_r + 1'b1;
      if (por_cnt_r == POR_W'(POR_DELAY - 1))
        por_done_r <= 1'b1;
    end
  end
  assign por_clr = !por_done_r && (por_cnt_r == POR_W'(POR_DELAY - 1));

  // presetn stands for power-on here: only it releases the blank lock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      blank_lock_r <= 1'b0;
    else if (sys_in.monitor_blank && !sys_in.tst_on_irq)
      blank_lock_r <= 1'b1;
  end

  // reset pulse generator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= WDT_IDLE;
      pulse_r <= '0;
      sys_reset_n_r <= 1'b1;
    end
    else
    begin
      case (state_r)
        WDT_IDLE:
        begin
          if (overflow)
          begin
            state_r <= WDT_PULSE;
            pulse_r <= PULSE_W'(`WDT_RST_PULSE - 1);
            sys_reset_n_r <= 1'b0;
          end
        end
        WDT_PULSE:
        begin
          if (pulse_r == '0)
          begin
            state_r <= WDT_IDLE;
            sys_reset_n_r <= 1'b1;
          end
          else
            pulse_r <= pulse_r - 1'b1;
        end
        default:
        begin
          state_r <= WDT_IDLE;
          sys_reset_n_r <= 1'b1;
        end
      endcase
    end
  end

  // stop instruction with stop disabled: one-cycle illegal reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      illegal_r <= 1'b0;
    else
      illegal_r <= sys_in.stop_exec && cfg_r.stop_disable;
  end

  // configuration and vector image writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r <= wdt_cfg_t'(CFG_W'(`WDT_CFG_RESET));
      vector_lo_r <= `WDT_VECTOR_RESET;
    end
    else if (wr && pstrb[0])
    begin
      if (paddr == `WDT_CONFIG_ADDR)
      begin
        cfg_r.timeout_rate_select <= pwdata[`WDT_CFG_RATE_BIT];
        cfg_r.watchdog_disable <= pwdata[`WDT_CFG_DIS_BIT];
        cfg_r.stop_disable <= pwdata[`WDT_CFG_STOPDIS_BIT];
      end
      else if (paddr == `WDT_VECTOR_ADDR)
        vector_lo_r <= pwdata[7:0];
    end
  end

  // sticky reset sources; a new event wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      src_r <= '0;
    else
    begin
      if (wr && pstrb[0] && paddr == `WDT_STATUS_ADDR)
      begin
        if (pwdata[0])
          src_r.watchdog_reset <= 1'b0;
        if (pwdata[1])
          src_r.illegal_stop <= 1'b0;
      end
      if (state_r == WDT_IDLE && overflow)
        src_r.watchdog_reset <= 1'b1;
      if (sys_in.stop_exec && cfg_r.stop_disable)
        src_r.illegal_stop <= 1'b1;
    end
  end

  // apb answer: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= 1'b0;
      if (setup)
      begin
        prdata_r <= '0;
        case (paddr)
          `WDT_CLEAR_ADDR:
            prdata_r <= {24'h000000, vector_lo_r};
          `WDT_CONFIG_ADDR:
            prdata_r <= {29'h00000000, cfg_r};
          `WDT_STATUS_ADDR:
            prdata_r <= {30'h00000000, src_r};
          `WDT_VECTOR_ADDR:
            prdata_r <= {24'h000000, vector_lo_r};
          default:
            pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  // no interrupt output exists; reset is the only action
  assign sys_reset_n = sys_reset_n_r;
  assign illegal_stop_reset = illegal_r;

  a_pulse_width: assert property (@(posedge pclk)
    disable iff (!presetn) $fell(sys_reset_n_r) |-> !sys_reset_n_r [*8]
    ##24 !sys_reset_n_r ##1 sys_reset_n_r)
    else $error("reset pulse width wrong");
  a_overflow_reset: assert property (@(posedge pclk)
    disable iff (!presetn) (overflow && state_r == WDT_IDLE) |=>
    !sys_reset_n_r)
    else $error("overflow gave no reset");
  a_disable_quiet: assert property (@(posedge pclk)
    disable iff (!presetn) cfg_r.watchdog_disable |-> !overflow)
    else $error("disabled watchdog overflowed");
  a_flag_sets: assert property (@(posedge pclk)
    disable iff (!presetn) $fell(sys_reset_n_r) |-> src_r.watchdog_reset)
    else $error("source flag not set");
  a_clear_read: assert property (@(posedge pclk)
    disable iff (!presetn) (setup && !pwrite && paddr == `WDT_CLEAR_ADDR)
    |=> prdata_r[7:0] == $past(vector_lo_r))
    else $error("clear location read wrong");
  a_monitor_off: assert property (@(posedge pclk)
    disable iff (!presetn) (sys_in.monitor_mode && sys_in.tst_on_irq)
    |-> !cnt_tick)
    else $error("monitor did not hold");
  a_break_off: assert property (@(posedge pclk)
    disable iff (!presetn) (sys_in.break_state && sys_in.tst_on_rst)
    |-> !run)
    else $error("break did not disable");
  a_illegal_stop: assert property (@(posedge pclk)
    disable iff (!presetn) (sys_in.stop_exec && cfg_r.stop_disable)
    |=> illegal_r)
    else $error("illegal stop missed");
  a_clear_wr: assert property (@(posedge pclk)
    disable iff (!presetn) clr_write |=> pre_count[11:4] == 8'h00)
    else $error("clear write left prescaler");
  a_blank_lock: assert property (@(posedge pclk)
    disable iff (!presetn) blank_lock_r |=> blank_lock_r && disabled)
    else $error("blank lock released");
  a_pulse_hold: assert property (@(posedge pclk)
    disable iff (!presetn) state_r == WDT_PULSE |-> !sys_reset_n_r)
    else $error("reset pin rose during pulse");
  a_fast_tap: assert property (@(posedge pclk)
    disable iff (!presetn) (cfg_r.timeout_rate_select && cnt_tick)
    |-> pre_count[6:0] == 7'h7f)
    else $error("fast rate tick off tap");
  // power-on, vector fetch, internal reset and disable clears must leave a full period behind them
  a_por_clear: assert property (@(posedge pclk)
    disable iff (!presetn) por_clr |=> pre_count == '0)
    else $error("power-on clear missed");
  a_vector_clear: assert property (@(posedge pclk)
    disable iff (!presetn) sys_in.vector_fetch |=> pre_count == '0)
    else $error("vector fetch left prescaler");
  a_ireset_clear: assert property (@(posedge pclk)
    disable iff (!presetn) sys_in.internal_reset |=>
    pre_count == '0 && u_cnt.cnt_r == '0)
    else $error("internal reset left counts");
  a_off_cleared: assert property (@(posedge pclk)
    disable iff (!presetn) disabled |=> pre_count == '0 && u_cnt.cnt_r == '0)
    else $error("disabled watchdog kept counts");
  c_timeout: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(sys_reset_n_r));
  c_clear: cover property (@(posedge pclk) disable iff (!presetn)
    clr_write);
  c_fast_rate: cover property (@(posedge pclk) disable iff (!presetn)
    cfg_r.timeout_rate_select && overflow);
  c_break_hold: cover property (@(posedge pclk) disable iff (!presetn)
    sys_in.break_state && sys_in.tst_on_rst);
  c_blank_lock: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(blank_lock_r));
endmodule
`default_nettype wire

// ### wdt_sys_model.sv
// system side model: cpu mode levels plus reset feedback
`timescale 1ns/1ns
`default_nettype none
module wdt_sys_model
  import wdt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_reset_n,
  input wire wdt_sys_t req,
  output var wdt_sys_t sys_in
);
  logic rst_seen_r;
  // reset pin low pulls the chip into internal reset one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_seen_r <= 1'b0;
    else
      rst_seen_r <= !sys_reset_n;
  end
  always_comb
  begin
    sys_in = req;
    sys_in.internal_reset = req.internal_reset | rst_seen_r;
  end
endmodule
`default_nettype wire

// ### watchdog_timeout_reset_tb_top.sv
// watchdog testbench: apb tasks and timeout scenarios
`timescale 1ns/1ns
`default_nettype none
`include "wdt_cfg.svh"
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("BAD %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module watchdog_timeout_reset_tb_top;
  import wdt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic sys_reset_n, illegal_stop_reset, er;
  wdt_sys_t req, sys_in;
  int error_cnt, total_checks, cyc, n, lows;
  wdt_top #(.POR_DELAY(16)) wdt_top_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_in(sys_in), .sys_reset_n(sys_reset_n),
    .illegal_stop_reset(illegal_stop_reset));
  wdt_sys_model wdt_sys_model_i (.pclk(pclk), .presetn(presetn),
    .sys_reset_n(sys_reset_n), .req(req), .sys_in(sys_in));
  always #4 pclk = ~pclk;
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard well above the longest expected run
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic apb(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait: only the hang guard ends a stuck access
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // counts reset pin activity over a window that should stay quiet
  task automatic quiet(input int len);
    lows = 0;
    repeat (len)
    begin
      @(posedge pclk);
      if (sys_reset_n !== 1'b1)
        lows++;
    end
  endtask
  // cycles from a clear until the reset pin drops
  task automatic wait_timeout;
    n = 0;
    while (sys_reset_n === 1'b1 && n < 9000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 4'hf;
    req = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `WDT_CONFIG_ADDR, 0);
    `CHK("cfg_reset", 32'h0, rd)
    apb(1, `WDT_VECTOR_ADDR, 32'h5a);
    apb(0, `WDT_CLEAR_ADDR, 0);
    `CHK("clear_read", 8'h5a, rd[7:0])
    apb(0, 32'h00000010, 0);
    `CHK("unmapped", 1'b1, er)
    apb(1, `WDT_CONFIG_ADDR, 32'h1);
    apb(1, `WDT_CLEAR_ADDR, 0);
    wait_timeout();
    `CHK("timeout", 1'b1, (n >= 8170 && n <= 8200))
    n = 0;
    while (sys_reset_n === 1'b0 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK("pulse_len", 32, n)
    apb(0, `WDT_STATUS_ADDR, 0);
    `CHK("wdt_source", 1'b1, rd[0])
    apb(1, `WDT_STATUS_ADDR, 32'h1);
    apb(0, `WDT_STATUS_ADDR, 0);
    `CHK("source_clr", 1'b0, rd[0])
    apb(1, `WDT_CONFIG_ADDR, 32'h1);
    apb(1, `WDT_CLEAR_ADDR, 0);
    quiet(6000);
    apb(1, `WDT_CLEAR_ADDR, 32'hff);
    quiet(6000);
    `CHK("refresh", 0, lows)
    apb(1, `WDT_CONFIG_ADDR, 32'h3);
    quiet(9000);
    `CHK("disabled", 0, lows)
    apb(1, `WDT_CONFIG_ADDR, 32'h1);
    apb(1, `WDT_CLEAR_ADDR, 0);
    req.stop_mode <= 1'b1;
    quiet(9000);
    `CHK("stop_gated", 0, lows)
    req.stop_mode <= 1'b0;
    apb(1, `WDT_CLEAR_ADDR, 0);
    req.monitor_mode <= 1'b1;
    req.tst_on_irq <= 1'b1;
    quiet(9000);
    `CHK("monitor_off", 0, lows)
    req <= '0;
    apb(1, `WDT_CLEAR_ADDR, 0);
    apb(1, `WDT_CONFIG_ADDR, 32'h5);
    req.stop_exec <= 1'b1;
    @(posedge pclk);
    req.stop_exec <= 1'b0;
    n = 0;
    repeat (6)
    begin
      @(posedge pclk);
      if (illegal_stop_reset === 1'b1)
        n++;
    end
    `CHK("illegal_pulse", 1, n)
    apb(0, `WDT_STATUS_ADDR, 0);
    `CHK("illegal_src", 1'b1, rd[1])
    req.break_state <= 1'b1;
    req.tst_on_rst <= 1'b1;
    req.vector_fetch <= 1'b1;
    @(posedge pclk);
    req.vector_fetch <= 1'b0;
    quiet(8500);
    `CHK("break_off", 0, lows)
    req <= '0;
    apb(1, `WDT_CLEAR_ADDR, 0);
    req.monitor_blank <= 1'b1;
    @(posedge pclk);
    req.monitor_blank <= 1'b0;
    quiet(8500);
    `CHK("blank_lock", 0, lows)
    // mid-run power-on: must release the blank lock and the config
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(0, `WDT_CONFIG_ADDR, 0);
    `CHK("cfg_rerun", 32'h0, rd)
    apb(1, `WDT_CONFIG_ADDR, 32'h1);
    apb(1, `WDT_CLEAR_ADDR, 0);
    wait_timeout();
    `CHK("lock_freed", 1'b1, (n >= 8170 && n <= 8200))
    stop_test();
  end
endmodule
`default_nettype wire
